// *** design/ephy_mux.sv ***
// Purpose: map client transmit/receive signals onto the phy data pins by mode
// Assumes: straps stable through reset, ignored after capture; rx clock runs while in use
// Notes:   receive beats cross by toggle; each beat held one rx clock
`timescale 1ns/100ps
`default_nettype none

// How it works
// - mode fixed by straps, not run-time
// - mii/gmii: tx enable is data enable
// - rgmii: tx enable is rising control half
// - mii/gmii: tx error is error control
// - rgmii: tx error is falling control half
// - mii: low nibble data, upper bits low
// - gmii: all eight transmit bits driven
// - rgmii: low nibble rising, high falling
// - serial modes: byte to transceiver
// - rgmii: rx valid/error are control halves
// - serial modes: rx valid is realign
// - mii: low receive nibble, upper ignored
// - gmii: whole receive byte per clock
// - rgmii: low nibble rising, high falling
// - serial modes: receive byte from transceiver
// - mii: collision used only half-duplex
// - mii: carrier sense only half-duplex
// - speed indicator high at 10/100
module ephy_mux
  import ephy_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       PHY_RX_CLOCK_IN,
  input  wire logic [2:0] MODE_SELECT,
  input  wire logic       GIGABIT_SELECT,
  input  wire logic       HALF_DUPLEX,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_ENABLE,
  input  wire logic       TX_ERROR,
  output logic            PHY_TX_ENABLE_OUT,
  output logic            PHY_TX_ERROR_OUT,
  output logic      [7:0] PHY_TX_DATA_OUT,
  input  wire logic       PHY_RX_VALID_IN,
  input  wire logic       PHY_RX_ERROR_IN,
  input  wire logic [7:0] PHY_RX_DATA_IN,
  input  wire logic       PHY_COLLISION_IN,
  input  wire logic       PHY_CARRIER_SENSE_IN,
  output logic            LOW_SPEED_INDICATOR,
  output logic      [7:0] RX_DATA,
  output logic            RX_VALID,
  output logic            RX_ERROR,
  output logic            RX_STROBE,
  output logic            TRANSCEIVER_REALIGN_FLAG,
  output logic            COLLISION,
  output logic            CARRIER_SENSE
);

  typedef struct packed {
    logic       mode_ok;
    ephy_mode_t mode;
    logic       giga;
    logic       half;
    logic       tx_en;
    logic       tx_er;
    logic [7:0] tx_d;
    logic       low_speed;
    logic       tog_seen;
    logic [7:0] rx_d;
    logic       rx_v;
    logic       rx_e;
    logic       rx_stb;
    logic       realign;
    logic       col;
    logic       crs;
  } ephy_core_st_t;

  ephy_core_st_t s;
  ephy_core_st_t next_s;

  logic [4:0] strap_s;
  logic [1:0] line_s;
  logic       rx_rst;
  logic [2:0] rx_mode;
  logic [7:0] hold_data;
  logic       hold_valid;
  logic       hold_error;
  logic       hold_realign;
  logic       hold_toggle;
  logic       tog_s;
  logic       beat;
  logic       is_mii;
  logic       is_gmii;
  logic       is_rgmii;
  logic       is_serial;

  // straps are pins: two flops before use; kept out of reset so the
  // synced value is settled at release, else capture would see zeros
  ephy_sync #(.W(5)) u_strap_sync (
    .clk (CLK),
    .rst (1'b0),
    .d   ({MODE_SELECT, GIGABIT_SELECT, HALF_DUPLEX}),
    .q   (strap_s)
  );

  // collision and carrier are asynchronous to both clocks
  ephy_sync #(.W(2)) u_line_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({PHY_COLLISION_IN, PHY_CARRIER_SENSE_IN}),
    .q   (line_s)
  );

  // reset into the receive domain; hold RST for at least three rx clocks
  ephy_sync #(.W(1)) u_rx_rst_sync (
    .clk (PHY_RX_CLOCK_IN),
    .rst (1'b0),
    .d   (RST),
    .q   (rx_rst)
  );

  // latched mode is static after capture, so a plain multi-bit sync is safe
  ephy_sync #(.W(3)) u_rx_mode_sync (
    .clk (PHY_RX_CLOCK_IN),
    .rst (rx_rst),
    .d   (s.mode),
    .q   (rx_mode)
  );

  ephy_rx_front u_rx_front (
    .rx_clk       (PHY_RX_CLOCK_IN),
    .rx_rst       (rx_rst),
    .mode         (rx_mode),
    .pin_valid    (PHY_RX_VALID_IN),
    .pin_error    (PHY_RX_ERROR_IN),
    .pin_data     (PHY_RX_DATA_IN),
    .hold_data    (hold_data),
    .hold_valid   (hold_valid),
    .hold_error   (hold_error),
    .hold_realign (hold_realign),
    .hold_toggle  (hold_toggle)
  );

  ephy_sync #(.W(1)) u_tog_sync (
    .clk (CLK),
    .rst (RST),
    .d   (hold_toggle),
    .q   (tog_s)
  );

  assign is_mii    = s.mode_ok && (s.mode == EPHY_MII);
  assign is_gmii   = s.mode_ok && (s.mode == EPHY_GMII);
  assign is_rgmii  = s.mode_ok && (s.mode == EPHY_RGMII);
  assign is_serial = s.mode_ok && ((s.mode == EPHY_SGMII) || (s.mode == EPHY_BASEX));
  assign beat      = tog_s ^ s.tog_seen;

  always_comb
  begin
    next_s = s;
    // capture once, on the first clock after reset release; later strap moves ignored
    if (!s.mode_ok)
    begin
      next_s.mode_ok = 1'b1;
      next_s.mode    = ephy_mode_t'(strap_s[4:2]);
      next_s.giga    = strap_s[1];
      next_s.half    = strap_s[0];
    end

    next_s.tx_en = EPHY_BIT_RST;
    next_s.tx_er = EPHY_BIT_RST;
    next_s.tx_d  = EPHY_BYTE_RST;
    if (is_mii)
    begin
      next_s.tx_en = TX_ENABLE;
      next_s.tx_er = TX_ERROR;
      next_s.tx_d  = {EPHY_NIBBLE_ZERO, TX_DATA[EPHY_NIB_LO+:4]};
    end
    else if (is_gmii)
    begin
      next_s.tx_en = TX_ENABLE;
      next_s.tx_er = TX_ERROR;
      next_s.tx_d  = TX_DATA;
    end
    else if (is_rgmii)
    begin
      // falling control half carries enable xor error
      next_s.tx_en = TX_ENABLE;
      next_s.tx_er = TX_ENABLE ^ TX_ERROR;
      next_s.tx_d  = {TX_DATA[EPHY_NIB_HI+:4], TX_DATA[EPHY_NIB_LO+:4]};
    end
    else if (is_serial)
    begin
      next_s.tx_d = TX_DATA;
    end

    // mii is always 10/100, gmii and base-x always gigabit
    next_s.low_speed = 1'b1;
    if (is_gmii || (s.mode_ok && s.mode == EPHY_BASEX))
      next_s.low_speed = 1'b0;
    else if (is_rgmii || (s.mode_ok && s.mode == EPHY_SGMII))
      next_s.low_speed = ~s.giga;

    // held words are stable a full rx period after the toggle moves
    next_s.tog_seen = tog_s;
    next_s.rx_stb   = beat;
    if (beat)
    begin
      next_s.rx_d    = hold_data;
      next_s.rx_v    = hold_valid;
      next_s.rx_e    = hold_error;
      next_s.realign = hold_realign;
    end

    // serial modes never look at collision, so an untied pin is harmless
    next_s.col = is_mii && s.half && line_s[1];
    next_s.crs = is_mii && s.half && line_s[0];
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      s <= '0;
    else
      s <= next_s;
  end

  assign PHY_TX_ENABLE_OUT        = s.tx_en;
  assign PHY_TX_ERROR_OUT         = s.tx_er;
  assign PHY_TX_DATA_OUT          = s.tx_d;
  assign LOW_SPEED_INDICATOR      = s.low_speed;
  assign RX_DATA                  = s.rx_d;
  assign RX_VALID                 = s.rx_v;
  assign RX_ERROR                 = s.rx_e;
  assign RX_STROBE                = s.rx_stb;
  assign TRANSCEIVER_REALIGN_FLAG = s.realign;
  assign COLLISION                = s.col;
  assign CARRIER_SENSE            = s.crs;

  // helper: stretch between receive strobes, for the crossing check
  logic [2:0] stb_gap;
  always_ff @(posedge CLK)
  begin
    if (RST || RX_STROBE)
      stb_gap <= 3'h0;
    else if (stb_gap != 3'h7)
      stb_gap <= stb_gap + 3'h1;
  end

  property p_mode_frozen;
    @(posedge CLK) disable iff (RST)
      s.mode_ok |=> s.mode_ok && $stable(s.mode) && $stable(s.half);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("interface mode changed after capture");

  sequence s_plain_mode;
    ##0 (is_mii || is_gmii);
  endsequence

  property p_tx_enable;
    @(posedge CLK) disable iff (RST)
      s_plain_mode ##1 s_plain_mode |-> PHY_TX_ENABLE_OUT == $past(TX_ENABLE);
  endproperty
  a_tx_enable: assert property (p_tx_enable)
    else $error("transmit enable does not follow client enable");

  property p_tx_error;
    @(posedge CLK) disable iff (RST)
      s_plain_mode ##1 s_plain_mode |-> PHY_TX_ERROR_OUT == $past(TX_ERROR);
  endproperty
  a_tx_error: assert property (p_tx_error)
    else $error("transmit error does not follow client error");

  property p_rgmii_ctl;
    @(posedge CLK) disable iff (RST)
      is_rgmii |=> (PHY_TX_ENABLE_OUT == $past(TX_ENABLE))
        && (PHY_TX_ERROR_OUT == $past(TX_ENABLE ^ TX_ERROR));
  endproperty
  a_rgmii_ctl: assert property (p_rgmii_ctl)
    else $error("rgmii transmit control halves wrong");

  property p_mii_upper;
    @(posedge CLK) disable iff (RST)
      is_mii |=> (PHY_TX_DATA_OUT[7:4] == EPHY_NIBBLE_ZERO)
        && (PHY_TX_DATA_OUT[3:0] == $past(TX_DATA[3:0]));
  endproperty
  a_mii_upper: assert property (p_mii_upper)
    else $error("mii transmit nibble mapping wrong");

  property p_byte_modes;
    @(posedge CLK) disable iff (RST)
      (is_gmii || is_rgmii || is_serial) |=> PHY_TX_DATA_OUT == $past(TX_DATA);
  endproperty
  a_byte_modes: assert property (p_byte_modes)
    else $error("transmit byte not passed through");

  property p_speed;
    @(posedge CLK) disable iff (RST)
      is_mii ##1 is_mii |-> LOW_SPEED_INDICATOR;
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed indicator low in mii mode");

  property p_gig_speed;
    @(posedge CLK) disable iff (RST)
      is_gmii ##1 is_gmii |-> !LOW_SPEED_INDICATOR;
  endproperty
  a_gig_speed: assert property (p_gig_speed)
    else $error("speed indicator high in gmii mode");

  property p_half_only;
    @(posedge CLK) disable iff (RST)
      !(is_mii && s.half) ##1 1'b1 |-> !COLLISION && !CARRIER_SENSE;
  endproperty
  a_half_only: assert property (p_half_only)
    else $error("collision or carrier seen outside mii half-duplex");

  property p_strobe_pulse;
    @(posedge CLK) disable iff (RST)
      RX_STROBE |=> !RX_STROBE;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("receive strobe longer than one cycle");

  property p_strobe_gap;
    @(posedge CLK) disable iff (RST)
      $rose(RX_STROBE) && stb_gap != 3'h0 |-> stb_gap >= 3'h3;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("receive beats closer than the crossing allows");

  property p_rx_hold;
    @(posedge CLK) disable iff (RST)
      !RX_STROBE |-> $stable(RX_DATA) && $stable(RX_VALID) && $stable(RX_ERROR);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive word moved without a strobe");

  property p_serial_tx_ctl;
    @(posedge CLK) disable iff (RST)
      is_serial |=> !PHY_TX_ENABLE_OUT && !PHY_TX_ERROR_OUT;
  endproperty
  a_serial_tx_ctl: assert property (p_serial_tx_ctl)
    else $error("transmit control driven in serial mode");

endmodule // ephy_mux
`default_nettype wire

// *** design/ephy_pkg.sv ***
// Purpose: shared constants and types of the phy-side signal mapper
// Assumes: interface mode and speed straps are static through reset; later moves are ignored
// Notes:   mode codes are local to this block
package ephy_pkg;

  typedef enum logic [2:0] {
    EPHY_MII   = 3'b000,
    EPHY_GMII  = 3'b001,
    EPHY_RGMII = 3'b010,
    EPHY_SGMII = 3'b011,
    EPHY_BASEX = 3'b100
  } ephy_mode_t;

  localparam int         EPHY_SYNC_STAGES = 2;
  localparam logic [7:0] EPHY_BYTE_RST    = 8'h00;
  localparam logic [3:0] EPHY_NIBBLE_ZERO = 4'h0;
  localparam logic       EPHY_BIT_RST     = 1'b0;
  localparam int         EPHY_NIB_LO      = 0;
  localparam int         EPHY_NIB_HI      = 4;
  localparam int         EPHY_STROBE_MAX  = 4;

endpackage

// *** design/ephy_rx_front.sv ***
// Purpose: receive pin capture and per-mode decode on the phy receive clock
// Assumes: pins are synchronous to rx_clk; mode is static
// Notes:   one beat per rx clock, handed over by a toggle and held words
`timescale 1ns/100ps
`default_nettype none
module ephy_rx_front
  import ephy_pkg::*;
(
  input  wire logic       rx_clk,
  input  wire logic       rx_rst,
  input  wire logic [2:0] mode,
  input  wire logic       pin_valid,
  input  wire logic       pin_error,
  input  wire logic [7:0] pin_data,
  output logic      [7:0] hold_data,
  output logic            hold_valid,
  output logic            hold_error,
  output logic            hold_realign,
  output logic            hold_toggle
);

  typedef struct packed {
    logic [9:0] p1;
    logic [9:0] p2;
    logic [7:0] d;
    logic       v;
    logic       e;
    logic       re;
    logic       tog;
  } ephy_rx_st_t;

  ephy_rx_st_t s;
  ephy_rx_st_t next_s;
  logic        dv;
  logic        er;
  logic [7:0]  pd;

  assign dv = s.p2[9];
  assign er = s.p2[8];
  assign pd = s.p2[7:0];

  always_comb
  begin
    next_s     = s;
    next_s.p1  = {pin_valid, pin_error, pin_data};
    next_s.p2  = s.p1;
    next_s.tog = ~s.tog;
    next_s.d   = pd;
    next_s.v   = EPHY_BIT_RST;
    next_s.e   = EPHY_BIT_RST;
    next_s.re  = EPHY_BIT_RST;
    case (ephy_mode_t'(mode))
      EPHY_MII:
      begin
        next_s.d = {EPHY_NIBBLE_ZERO, pd[EPHY_NIB_LO+:4]};
        next_s.v = dv;
        next_s.e = er;
      end
      EPHY_GMII:
      begin
        next_s.v = dv;
        next_s.e = er;
      end
      EPHY_RGMII:
      begin
        next_s.v = dv;
        next_s.e = dv ^ er;
        next_s.d = pd;
      end
      EPHY_SGMII, EPHY_BASEX:
      begin
        next_s.v  = 1'b1;
        next_s.d  = pd;
        next_s.re = dv;
      end
      default:
      begin
        next_s.d = EPHY_BYTE_RST;
      end
    endcase
  end

  always_ff @(posedge rx_clk)
  begin
    if (rx_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign hold_data    = s.d;
  assign hold_valid   = s.v;
  assign hold_error   = s.e;
  assign hold_realign = s.re;
  assign hold_toggle  = s.tog;

  property p_mii_hi_zero;
    @(posedge rx_clk) disable iff (rx_rst)
      (mode == EPHY_MII) && $stable(mode) |=> (s.d[7:4] == EPHY_NIBBLE_ZERO);
  endproperty
  a_mii_hi_zero: assert property (p_mii_hi_zero)
    else $error("upper receive nibble not zero in mii mode");

  property p_serial_realign;
    @(posedge rx_clk) disable iff (rx_rst)
      ((mode == EPHY_SGMII) || (mode == EPHY_BASEX)) && $stable(mode)
        |=> (s.re == $past(dv)) && s.v;
  endproperty
  a_serial_realign: assert property (p_serial_realign)
    else $error("realign flag does not follow valid pin in serial mode");

endmodule // ephy_rx_front
`default_nettype wire

// *** design/ephy_sync.sv ***
// Purpose: two-flop level synchroniser, any width
// Assumes: multi-bit use only for quasi-static values
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module ephy_sync
  import ephy_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ephy_sync_st_t;

  ephy_sync_st_t s;
  ephy_sync_st_t next_s;

  always_comb
  begin
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.stable;

endmodule // ephy_sync
`default_nettype wire

// *** dv/ephy_phy_model.sv ***
// Purpose: behavioural phy / serial transceiver receive side
// Assumes: mode input matches the device straps
// Notes:   drives an idle pattern of zeros between frames
`timescale 1ns/100ps
`default_nettype none
module ephy_phy_model
  import ephy_pkg::*;
(
  input  wire logic       rx_clk,
  input  wire logic [2:0] mode,
  input  wire logic       run,
  input  wire logic       col_lvl,
  input  wire logic       crs_lvl,
  output logic            dv,
  output logic            er,
  output logic      [7:0] d,
  output logic            sof,
  output logic            col,
  output logic            crs
);
  int   left;
  logic serial;
  assign serial = (mode == EPHY_SGMII) || (mode == EPHY_BASEX);
  assign col    = col_lvl && !serial;
  assign crs    = crs_lvl;
  initial
  begin
    left = 0;
    dv   = 1'b0;
    er   = 1'b0;
    d    = 8'h00;
    sof  = 1'b0;
  end
  // first beat of a frame is a fixed marker so the bench can align
  always @(posedge rx_clk)
  begin
    sof <= 1'b0;
    if (run && left > 0)
    begin
      left <= left - 1;
      dv   <= serial ? ($urandom_range(7) == 0) : 1'b1;
      er   <= ($urandom_range(15) == 0);
      d    <= 8'($urandom);
    end
    else if (run && $urandom_range(3) == 0)
    begin
      left <= $urandom_range(20, 4);
      sof  <= 1'b1;
      dv   <= !serial;
      er   <= 1'b0;
      d    <= 8'hA5;
    end
    else
    begin
      left <= 0;
      dv <= 1'b0;
      er <= 1'b0;
      d  <= 8'h00;
    end
  end
endmodule // ephy_phy_model
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the phy-side signal mapper
// Assumes: one reset per strap setting, since mode is latched at reset
// Notes:   tx and rx results checked through queues of expectations
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ephy_pkg::*;
  logic       clk, rst, rx_clk, gig, half, en, er, run, col_lvl, crs_lvl;
  logic [2:0] mode;
  logic [7:0] txd, pd, ptx_d, rxd;
  logic       pdv, per, sof, pcol, pcrs, ptx_en, ptx_er, lsi, rxv, rxe, rxs, rxr, coll, cs;
  logic       rx_push, rx_armed, w_armed;
  logic [9:0] tx_q[$];
  logic [10:0] rx_q[$];
  int         check_count, n_mismatch, cycles;
  logic [4:0] cfg[9] = '{5'h00, 5'h01, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h12};
  initial
  begin
    {clk, rst, rx_clk, gig, half, en, er, run, col_lvl, crs_lvl} = 10'h102;
    {mode, txd, rx_push, rx_armed, w_armed} = 14'h0;
    {check_count, n_mismatch, cycles} = '0;
  end
  always #5 clk = ~clk;
  initial
  begin
    #7;
    forever #24 rx_clk = ~rx_clk;
  end
  ephy_mux uut (.CLK(clk), .RST(rst), .PHY_RX_CLOCK_IN(rx_clk), .MODE_SELECT(mode),
    .GIGABIT_SELECT(gig), .HALF_DUPLEX(half), .TX_DATA(txd), .TX_ENABLE(en),
    .TX_ERROR(er), .PHY_TX_ENABLE_OUT(ptx_en), .PHY_TX_ERROR_OUT(ptx_er),
    .PHY_TX_DATA_OUT(ptx_d), .PHY_RX_VALID_IN(pdv), .PHY_RX_ERROR_IN(per),
    .PHY_RX_DATA_IN(pd), .PHY_COLLISION_IN(pcol), .PHY_CARRIER_SENSE_IN(pcrs),
    .LOW_SPEED_INDICATOR(lsi), .RX_DATA(rxd), .RX_VALID(rxv), .RX_ERROR(rxe),
    .RX_STROBE(rxs), .TRANSCEIVER_REALIGN_FLAG(rxr), .COLLISION(coll), .CARRIER_SENSE(cs));
  ephy_phy_model phy (.rx_clk(rx_clk), .mode(mode), .run(run), .col_lvl(col_lvl),
    .crs_lvl(crs_lvl), .dv(pdv), .er(per), .d(pd), .sof(sof), .col(pcol), .crs(pcrs));
  function automatic logic [9:0] exp_tx(logic [2:0] m, logic e, logic r, logic [7:0] x);
    case (m)
      EPHY_MII:   return {e, r, 4'h0, x[3:0]};
      EPHY_GMII:  return {e, r, x};
      EPHY_RGMII: return {e, e ^ r, x};
      default:    return {2'b00, x};
    endcase
  endfunction
  function automatic logic [10:0] exp_rx(logic [2:0] m, logic v, logic r, logic [7:0] x);
    case (m)
      EPHY_MII:   return {4'h0, x[3:0], v, r, 1'b0};
      EPHY_GMII:  return {x, v, r, 1'b0};
      EPHY_RGMII: return {x, v, v ^ r, 1'b0};
      default:    return {x, 1'b1, 1'b0, v};
    endcase
  endfunction
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // beats seen at the pins become notes; alignment starts at a frame marker
  always @(posedge rx_clk)
    if (rx_push && (rx_armed || sof))
    begin
      rx_armed = 1'b1;
      rx_q.push_back(exp_rx(mode, pdv, per, pd));
    end
  // idle strobes before the marker carry zero data and are skipped
  always @(posedge clk)
    if (rxs === 1'b1 && rx_q.size() > 0 && (w_armed || rxd !== 8'h00))
    begin
      w_armed = 1'b1;
      check("rx beat", rx_q.pop_front(), {rxd, rxv, rxe, rxr});
    end
  always @(negedge clk)
    if (tx_q.size() > 0)
      check("tx pins", tx_q.pop_front(), {ptx_en, ptx_er, ptx_d});
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic run_cfg(logic [4:0] c);
    logic lo;
    logic hd;
    rst  <= 1'b1;
    mode <= c[4:2];
    gig  <= c[1];
    half <= c[0];
    repeat (24) @(posedge clk);
    tx_q.delete();
    rx_q.delete();
    rx_armed = 1'b0;
    w_armed  = 1'b0;
    rst     <= 1'b0;
    repeat (6) @(posedge clk);
    lo = (c[4:2] == EPHY_MII) || (!c[1] && (c[4:2] == EPHY_RGMII || c[4:2] == EPHY_SGMII));
    hd = (c[4:2] == EPHY_MII) && c[0];
    check("speed", lo, lsi);
    run     <= 1'b1;
    rx_push  = 1'b1;
    repeat (400)
    begin
      @(posedge clk);
      tx_q.push_back(exp_tx(mode, en, er, txd));
      en  <= 1'($urandom);
      er  <= ($urandom_range(7) == 0);
      txd <= 8'($urandom);
    end
    // straps move after capture; the captured setting must stay in force
    gig  <= ~c[1];
    half <= ~c[0];
    for (int lv = 1; lv >= 0; lv--)
    begin
      col_lvl <= 1'(lv);
      crs_lvl <= 1'(lv);
      repeat (6) @(posedge clk);
      check("collision", hd && lv, coll);
      check("carrier", hd && lv, cs);
    end
    check("speed held", lo, lsi);
    rx_push = 1'b0;
    run    <= 1'b0;
    repeat (40) @(posedge clk);
    check("rx drained", 16'h0, 16'(rx_q.size()));
  endtask
  initial
  begin
    void'($urandom(32'hA2E9));
    repeat (8) @(posedge clk);
    foreach (cfg[i])
      run_cfg(cfg[i]);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
